// [hw/gim_defs.svh]
// constants for the group-one global interrupt mask block
`ifndef GIM_DEFS_SVH
`define GIM_DEFS_SVH

// ==========================================================
// register map
`define GIM_MASK_ADDR      8'h08
`define GIM_MASK_RESET     7'h7f
`define GIM_NUM_SRC        7

// ==========================================================
// mask and flag bit positions
`define GIM_BIT_B_FALL     0
`define GIM_BIT_B_RISE     1
`define GIM_BIT_C_FALL     2
`define GIM_BIT_C_RISE     3
`define GIM_BIT_BB_TO      4
`define GIM_BIT_LDO_A      5
`define GIM_BIT_LDO_B      6
`define GIM_BIT_UNUSED     7

`endif

// [hw/gim_pkg.sv]
// types shared by the group-one global interrupt mask block
package gim_pkg;

  // one bit per source, laid out as the mask register bits 6..0
  typedef struct packed {
    logic ldo_b_fault_flag;
    logic ldo_a_fault_flag;
    logic buckboost_timeout_flag;
    logic input_c_rise_flag;
    logic input_c_fall_flag;
    logic input_b_rise_flag;
    logic input_b_fall_flag;
  } gim_src_type;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wdata;
  } gim_reg_req_type;

endpackage

// [hw/gim_flag_cell.sv]
// one sticky interrupt flag with its rising-edge detect
`timescale 1ns/100ps
module gim_flag_cell (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // event and clear
  input  wire logic event_in,
  input  wire logic clear_in,
  // flag state
  output logic      flag,
  output logic      flag_nxt,
  output logic      rise
);

  logic flag_r;

  // set wins over the read clear so no event is lost
  always_comb begin
    flag_nxt = event_in | (flag_r & ~clear_in);
    rise     = flag_nxt & ~flag_r;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule

// [hw/gim_irq_mask1.sv]
// group-one global interrupt mask register and interrupt line control
//
// Contract
// [R01] host writes zero to top bit; read meaningless
// [R02] unmasked ldo fault rise pulls line low
// [R03] unmasked buck-boost timeout rise pulls line low
// [R04] unmasked input rise flag rise pulls low
// [R05] unmasked input fall flag rise pulls low
// [R06] line released only when all flags clear
// [R07] masked flag rise never pulls line low
// [R08] flags sticky until their register is read
// [R09] status bit mirrors unmasked gate drive
// [R10] mask resets to all ones, top zero
`timescale 1ns/100ps
`include "gim_defs.svh"
module gim_irq_mask1
  import gim_pkg::*;
#(
  parameter int NUM_SRC = `GIM_NUM_SRC
) (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            nrst,
  // register port
  input  wire gim_reg_req_type reg_req,
  output logic [7:0]           reg_rdata,
  // flag events and flag-register read clears
  input  wire gim_src_type     src_event,
  input  wire gim_src_type     src_clear,
  input  wire logic            other_flags_any,
  output gim_src_type          src_flags,
  // open-drain interrupt line and its status mirror
  output logic                 irq_out_n_o,
  output logic                 irq_out_n_oe,
  output logic                 irq_gate_status
);

  // ==========================================================
  // elaboration check: read word and reset value assume seven sources
  if (NUM_SRC != `GIM_NUM_SRC) begin : g_bad_num_src
    $error("gim_irq_mask1: NUM_SRC must be 7");
  end

  // ==========================================================
  // flag cells
  logic [NUM_SRC-1:0] ev_v;
  logic [NUM_SRC-1:0] clr_v;
  logic [NUM_SRC-1:0] flag_v;
  logic [NUM_SRC-1:0] flag_nxt_v;
  logic [NUM_SRC-1:0] rise_v;

  assign ev_v  = src_event;
  assign clr_v = src_clear;

  // [R08] sticky flags cleared by read
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_cell
    gim_flag_cell u_cell (
      .clock    (clock),
      .nrst     (nrst),
      .event_in (ev_v[i]),
      .clear_in (clr_v[i]),
      .flag     (flag_v[i]),
      .flag_nxt (flag_nxt_v[i]),
      .rise     (rise_v[i])
    );
  end

  assign src_flags = flag_v;

  // ==========================================================
  // mask register and read data
  logic [NUM_SRC-1:0] mask_r;
  logic [NUM_SRC-1:0] mask_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic               hit;

  // address decode, write store and registered read
  always_comb begin
    hit       = (reg_req.addr == `GIM_MASK_ADDR);
    mask_nxt  = mask_r;
    rdata_nxt = rdata_r;
    if (reg_req.wr_en && hit) begin
      // [R01] top bit dropped, host keeps it zero
      mask_nxt = reg_req.wdata[NUM_SRC-1:0];
    end
    if (reg_req.rd_en && hit) begin
      // [R10] top bit always reads zero
      rdata_nxt = {1'b0, mask_r};
    end else if (reg_req.rd_en) begin
      rdata_nxt = 8'h00; // unmapped reads return zero
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // [R10] all sources masked at reset
      mask_r  <= `GIM_MASK_RESET;
      rdata_r <= 8'h00;
    end else begin
      mask_r  <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // interrupt line state
  logic irq_r;
  logic irq_nxt;
  logic unmasked_rise;

  // set beats release: a new rise while flags clear keeps line low
  always_comb begin
    // [R02] [R03] [R04] [R05] [R07] mask gates edges
    unmasked_rise = |(rise_v & ~mask_r);
    irq_nxt       = irq_r;
    if (unmasked_rise) begin
      irq_nxt = 1'b1;
    end else if (~|flag_nxt_v && !other_flags_any) begin
      // [R06] release needs every flag cleared
      irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // open drain: only ever pulls low
  assign irq_out_n_o  = 1'b0;
  assign irq_out_n_oe = irq_r;
  // [R09] software copy of the gate drive
  assign irq_gate_status = irq_r;

  // ==========================================================
  // checks
  ldo_fault_irq_a: assert property ( // [R02]
    @(posedge clock) disable iff (!nrst)
    (rise_v[`GIM_BIT_LDO_A] && !mask_r[`GIM_BIT_LDO_A]) ||
    (rise_v[`GIM_BIT_LDO_B] && !mask_r[`GIM_BIT_LDO_B])
    |=> irq_out_n_oe)
    else $error("ldo fault rise did not pull line low");

  bb_timeout_irq_a: assert property ( // [R03]
    @(posedge clock) disable iff (!nrst)
    rise_v[`GIM_BIT_BB_TO] && !mask_r[`GIM_BIT_BB_TO]
    |=> irq_out_n_oe && src_flags.buckboost_timeout_flag)
    else $error("timeout rise did not pull line low");

  input_rise_irq_a: assert property ( // [R04]
    @(posedge clock) disable iff (!nrst)
    (ev_v[`GIM_BIT_C_RISE] && !flag_v[`GIM_BIT_C_RISE] &&
     !mask_r[`GIM_BIT_C_RISE]) ||
    (ev_v[`GIM_BIT_B_RISE] && !flag_v[`GIM_BIT_B_RISE] &&
     !mask_r[`GIM_BIT_B_RISE])
    |=> irq_out_n_oe)
    else $error("input rise flag did not pull line low");

  input_fall_irq_a: assert property ( // [R05]
    @(posedge clock) disable iff (!nrst)
    (rise_v[`GIM_BIT_C_FALL] && !mask_r[`GIM_BIT_C_FALL]) ||
    (rise_v[`GIM_BIT_B_FALL] && !mask_r[`GIM_BIT_B_FALL])
    |=> irq_out_n_oe)
    else $error("input fall flag did not pull line low");

  release_all_clear_a: assert property ( // [R06]
    @(posedge clock) disable iff (!nrst)
    $fell(irq_out_n_oe) |-> (flag_v == '0) && !$past(other_flags_any))
    else $error("line released with a flag still set");

  masked_no_irq_a: assert property ( // [R07]
    @(posedge clock) disable iff (!nrst)
    !irq_r && (rise_v != '0) && ((rise_v & ~mask_r) == '0)
    |=> !irq_out_n_oe)
    else $error("masked flag pulled line low");

  flag_sticky_a: assert property ( // [R08]
    @(posedge clock) disable iff (!nrst)
    1'b1 |=> (($past(flag_v) & ~$past(clr_v) & ~flag_v) == '0))
    else $error("flag dropped without a read clear");

  gate_status_a: assert property ( // [R09]
    @(posedge clock) disable iff (!nrst)
    irq_gate_status == irq_out_n_oe && irq_out_n_o == 1'b0)
    else $error("status bit differs from gate drive");

  mask_reset_a: assert property ( // [R10]
    @(posedge clock) disable iff (!nrst)
    $rose(nrst) |-> mask_r == `GIM_MASK_RESET && !irq_r)
    else $error("mask not all ones after reset");

  top_bit_zero_a: assert property ( // [R10]
    @(posedge clock) disable iff (!nrst)
    reg_req.rd_en && hit |=> reg_rdata[`GIM_BIT_UNUSED] == 1'b0)
    else $error("unused top bit read as one");

  // write store, read data, line hold and set-wins checks
  mask_write_a: assert property ( // [R01]
    @(posedge clock) disable iff (!nrst)
    reg_req.wr_en && hit |=>
    mask_r == $past(reg_req.wdata[NUM_SRC-1:0]))
    else $error("mask write did not land");

  read_data_a: assert property ( // [R10]
    @(posedge clock) disable iff (!nrst)
    reg_req.rd_en && hit |=> reg_rdata == {1'b0, $past(mask_r)})
    else $error("read data differs from mask");

  unmapped_read_a: assert property ( // [R10]
    @(posedge clock) disable iff (!nrst)
    reg_req.rd_en && !hit |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero");

  line_hold_a: assert property ( // [R06]
    @(posedge clock) disable iff (!nrst)
    irq_r && ((flag_nxt_v != '0) || other_flags_any) |=> irq_out_n_oe)
    else $error("line released with a flag pending");

  set_wins_a: assert property ( // [R08]
    @(posedge clock) disable iff (!nrst)
    1'b1 |=> (($past(ev_v) & ~flag_v) == '0))
    else $error("event did not leave its flag set");

endmodule

// [verif/gim_host_model.sv]
// host model: pulled-up open-drain interrupt line
`timescale 1ns/100ps
module gim_host_model (
  // pin from the device
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // level seen by the host
  output logic      line
);
  // pull-up wins whenever nobody pulls low
  assign line = pin_oe ? pin_o : 1'b1;
endmodule

// [verif/tb_top.sv]
// testbench for the group-one interrupt mask block
`timescale 1ns/100ps
module tb_top
  import gim_pkg::*;
;
  logic            clock = 1'b0;
  logic            nrst  = 1'b0;
  gim_reg_req_type req   = '0;
  gim_src_type     ev    = '0;
  gim_src_type     clr   = '0;
  logic            oth   = 1'b0;
  logic [7:0]      rdata;
  gim_src_type     flags;
  logic            od_o;
  logic            od_oe;
  logic            gate;
  logic            line;
  logic [7:0]      d;
  int              error_cnt   = 0;
  int              comparisons = 0;

  // 50 MHz clock
  always #10 clock = ~clock;

  gim_irq_mask1 dut (.clock(clock), .nrst(nrst), .reg_req(req),
    .reg_rdata(rdata), .src_event(ev), .src_clear(clr),
    .other_flags_any(oth), .src_flags(flags), .irq_out_n_o(od_o),
    .irq_out_n_oe(od_oe), .irq_gate_status(gate));
  gim_host_model host (.pin_o(od_o), .pin_oe(od_oe), .line(line));

  // ==========================================================
  // helpers
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task step;
    @(posedge clock);
    #1;
  endtask
  // a spare edge keeps back-to-back strobes apart
  task wr(input logic [7:0] a, input logic [7:0] v);
    req = '{addr: a, wr_en: 1'b1, rd_en: 1'b0, wdata: v};
    step;
    req.wr_en = 1'b0;
    step;
  endtask
  task rd(input logic [7:0] a);
    req.addr  = a;
    req.rd_en = 1'b1;
    step;
    req.rd_en = 1'b0;
    step;
    d = rdata;
  endtask
  task pulse(input gim_src_type e, input gim_src_type c);
    ev  = e;
    clr = c;
    step;
    ev  = '0;
    clr = '0;
    step;
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task t_reset;
    rd(8'h08);
    chk(d, 8'h7f);
    rd(8'h33);
    chk(d, 8'h00);
    chk({7'h00, line}, 8'h01);
    $display("test reset done");
  endtask
  // each source alone: unmasked rise pulls low, clear releases
  task t_each;
    for (int i = 0; i < 7; i++) begin
      wr(8'h08, 8'h7f & ~(8'h01 << i));
      pulse(gim_src_type'(7'h01 << i), '0);
      chk({7'h00, line}, 8'h00);
      chk({7'h00, gate}, 8'h01);
      step;
      chk({1'b0, flags}, 8'h01 << i);
      pulse('0, gim_src_type'(7'h01 << i));
      chk({7'h00, line}, 8'h01);
      chk({7'h00, gate}, 8'h00);
    end
    $display("test each source done");
  endtask
  // masked sources set flags but leave the line high
  task t_masked;
    wr(8'h08, 8'h7f);
    pulse(7'h7f, '0);
    chk({1'b0, flags}, 8'h7f);
    chk({7'h00, line}, 8'h01);
    pulse('0, 7'h7f);
    chk({1'b0, flags}, 8'h00);
    $display("test masked done");
  endtask
  // line stays low until every flag is gone
  task t_partial;
    wr(8'h08, 8'h00);
    wr(8'h20, 8'h7f);
    pulse(7'h21, '0);
    pulse('0, 7'h01);
    chk({7'h00, line}, 8'h00);
    oth = 1'b1;
    pulse('0, 7'h20);
    chk({7'h00, line}, 8'h00);
    oth = 1'b0;
    step;
    chk({7'h00, line}, 8'h01);
    rd(8'h08);
    chk(d, 8'h00);
    $display("test partial clear done");
  endtask
  // edge only: unmasking a set flag or re-hitting it stays quiet
  task t_edge;
    wr(8'h08, 8'h7f);
    pulse(7'h02, '0);
    wr(8'h08, 8'h7d);
    chk({7'h00, line}, 8'h01);
    pulse(7'h02, 7'h02);
    chk({1'b0, flags}, 8'h02);
    chk({7'h00, line}, 8'h01);
    pulse('0, 7'h02);
    chk({1'b0, flags}, 8'h00);
    pulse(7'h02, 7'h02);
    chk({7'h00, line}, 8'h00);
    chk({1'b0, flags}, 8'h02);
    chk({7'h00, gate}, 8'h01);
    pulse('0, 7'h02);
    chk({7'h00, line}, 8'h01);
    rd(8'h08);
    chk(d, 8'h7d);
    $display("test edge only done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge clock);
    #1;
    nrst = 1'b1;
    step;
    t_reset;
    t_each;
    t_masked;
    t_partial;
    t_edge;
    final_report;
  end
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
endmodule
